// >>> stm_timer.sv
// standard timer: pwm, single pulse and capture modes with register port
`timescale 1ns/1ns
// How it works
// - swap set: period from a, duty p*256
// - period-source match clears counter, new period
// - pwm keeps running while pin forced
// - clear-source bit ignored in pwm
// - run rising starts counter and pulse
// - trigger pin edge sets run bit
// - software clear or a match ends pulse
// - a match in pulse mode raises irq
// - pulse counter zeroed only by run rising
// - capture from pin or filter output
// - active edge latches counter into a
// - capture counter free-runs until run falls
// - p match clears counter, raises irq
// - pin field picks edge, 11 disables
// - level, polarity, clear, swap ignored
// - pin transitions capture even when output
// - p against top byte, zero 65536
module stm_timer #(
    parameter int W = 16  // counter width
) (
    input  wire logic       mclk,                   // system clock, 20 MHz
    input  wire logic       rst_n,                  // async reset, active low
    input  wire logic [3:0] addr,                   // register offset
    input  wire logic [7:0] wdata,                  // write data
    input  wire logic       wr,                     // write strobe
    input  wire logic       rd,                     // read strobe
    output logic      [7:0] rdata,                  // read data, cycle after rd
    input  wire logic       external_trigger_pin,   // single pulse trigger
    input  wire logic       capture_input_pin,      // capture source pin
    input  wire logic       noise_filter_input_pin, // filtered capture source
    output logic            timer_out,              // timer output pin level
    output logic            timer_irq               // one-cycle match/capture request
);

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    logic [7:0]      ctrl0;               // run, trigger edge, capture source
    stm_pkg::stm_cfg_t cfg;               // ctrl1 fields
    logic [W-1:0]    cnt;                 // counter
    logic [W-1:0]    compare_register_a;  // compare a / capture latch
    logic [7:0]      compare_register_p;  // compare p
    logic [1:0]      flags;               // sticky [1]=p match [0]=a match/capture
    logic            wave;                // raw waveform before polarity

    logic            run;                 // timer_run_bit
    logic            run_rise;            // run 0->1
    logic            run_fall;            // run 1->0
    logic            trg_rise;            // trigger pin rising
    logic            trg_fall;            // trigger pin falling
    logic            cap_rise;            // capture source rising
    logic            cap_fall;            // capture source falling
    logic            hit_a;               // comparator a
    logic            hit_p;               // comparator p
    logic            cap_src;             // selected capture level

    // ----------------------------------------------------------------
    // mode decode
    // ----------------------------------------------------------------
    wire is_cap   = (cfg.mode == stm_pkg::MODE_CAP);
    wire is_pwmm  = (cfg.mode == stm_pkg::MODE_PWM);
    wire is_pulse = is_pwmm && (cfg.pinf == stm_pkg::PINF_ONE);
    wire is_pwm   = is_pwmm && !is_pulse;
    wire wr_ctrl0 = wr && (addr == stm_pkg::ADDR_CTRL0);
    wire wr_ctrl1 = wr && (addr == stm_pkg::ADDR_CTRL1);

    assign run = ctrl0[stm_pkg::POS_RUN];

    // ----------------------------------------------------------------
    // edge detectors and comparators
    // ----------------------------------------------------------------
    // capture source: pin or filter output; pin edges count even if it drives out
    assign cap_src = ctrl0[stm_pkg::POS_SRC] ? noise_filter_input_pin
                                             : capture_input_pin;

    stm_edge u_run_edge (
        .mclk  (mclk),
        .rst_n (rst_n),
        .din   (run),
        .rise  (run_rise),
        .fall  (run_fall)
    );

    stm_edge u_trg_edge (
        .mclk  (mclk),
        .rst_n (rst_n),
        .din   (external_trigger_pin),
        .rise  (trg_rise),
        .fall  (trg_fall)
    );

    stm_edge u_cap_edge (
        .mclk  (mclk),
        .rst_n (rst_n),
        .din   (cap_src),
        .rise  (cap_rise),
        .fall  (cap_fall)
    );

    stm_cmp #(
        .W (W)
    ) u_cmp (
        .cnt   (cnt),
        .cmpa  (compare_register_a),
        .cmpp  (compare_register_p),
        .hit_a (hit_a),
        .hit_p (hit_p)
    );

    // ----------------------------------------------------------------
    // event decode
    // ----------------------------------------------------------------
    // capture edge select; 11 disables capture only
    wire cap_evt = is_cap && run && (
                   (cfg.pinf == stm_pkg::PINF_LOW  && cap_rise) ||
                   (cfg.pinf == stm_pkg::PINF_HIGH && cap_fall) ||
                   (cfg.pinf == stm_pkg::PINF_PWM  && (cap_rise | cap_fall)));
    // trigger pin active edge, chosen in ctrl0
    wire trg_evt = is_pulse && !run &&
                   (ctrl0[stm_pkg::POS_TEDGE] ? trg_fall : trg_rise);
    // a match ends the pulse and drops the run bit
    wire pulse_end = is_pulse && run && hit_a && !run_rise;
    // pwm period end: swap picks which comparator clears; clear-source ignored
    wire pwm_clr = cfg.swap ? hit_a : hit_p;
    // pwm duty: compare to a, or p*256 (p zero = whole 65536)
    wire [W:0] duty_p = (compare_register_p == 8'h00) ? (W+1)'(stm_pkg::FULL_PERIOD)
                      : {1'b0, compare_register_p, 8'h00};
    wire [W:0] duty   = cfg.swap ? duty_p : {1'b0, compare_register_a};
    wire       pwm_act = ({1'b0, cnt} < duty);
    // irq sources per mode
    wire irq_a = (is_pulse && pulse_end) || cap_evt ||
                 (is_pwm && run && hit_a);
    wire irq_p = (is_cap && run && hit_p) || (is_pwm && run && hit_p);

    // ----------------------------------------------------------------
    // counter next value
    // ----------------------------------------------------------------
    logic [W-1:0] next_cnt;
    always_comb begin
        next_cnt = cnt;
        if (run_rise) begin
            next_cnt = '0;
        end else if (!run) begin
            next_cnt = cnt;                         // stopped, holds value
        end else if (is_cap) begin
            next_cnt = hit_p ? '0 : cnt + 1'b1;
        end else if (is_pwm) begin
            next_cnt = pwm_clr ? '0 : cnt + 1'b1;
        end else if (is_pulse) begin
            next_cnt = pulse_end ? cnt : cnt + 1'b1;
        end else begin
            next_cnt = cnt + 1'b1;                  // other modes just count
        end
    end

    // ----------------------------------------------------------------
    // run bit: software write, trigger set, match clear
    // ----------------------------------------------------------------
    logic next_run;
    always_comb begin
        next_run = run;
        if (wr_ctrl0) begin
            next_run = wdata[stm_pkg::POS_RUN];
        end
        if (pulse_end) begin
            next_run = 1'b0;
        end
        if (trg_evt) begin
            next_run = 1'b1;
        end
    end

    // control register 0
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl0 <= stm_pkg::RST_BYTE;
        end else begin
            if (wr_ctrl0) begin
                ctrl0 <= {wdata[7:6], 5'h00, next_run};
            end else begin
                ctrl0 <= {ctrl0[7:6], 5'h00, next_run};
            end
        end
    end

    // control register 1
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cfg <= stm_pkg::stm_cfg_t'(stm_pkg::RST_BYTE);
        end else if (wr_ctrl1) begin
            cfg <= stm_pkg::stm_cfg_t'(wdata);
        end
    end

    // counter
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= stm_pkg::RST_WORD;
        end else begin
            cnt <= next_cnt;
        end
    end

    // compare a: software write or capture latch; capture wins
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            compare_register_a <= stm_pkg::RST_WORD;
        end else if (cap_evt) begin
            compare_register_a <= cnt;
        end else if (wr && addr == stm_pkg::ADDR_CMPA_LO) begin
            compare_register_a[7:0] <= wdata;
        end else if (wr && addr == stm_pkg::ADDR_CMPA_HI) begin
            compare_register_a[15:8] <= wdata;
        end
    end

    // compare p
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            compare_register_p <= stm_pkg::RST_BYTE;
        end else if (wr && addr == stm_pkg::ADDR_CMPP) begin
            compare_register_p <= wdata;
        end
    end

    // sticky flags: set beats write-one-to-clear
    wire [1:0] flag_clr = (wr && addr == stm_pkg::ADDR_STATUS) ? wdata[1:0] : 2'h0;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            flags <= 2'h0;
        end else begin
            flags <= (flags & ~flag_clr) | {irq_p, irq_a};
        end
    end

    // ----------------------------------------------------------------
    // output waveform
    // ----------------------------------------------------------------
    // wave is the active level before the initial-level/polarity mapping;
    // capture mode leaves the pin at rest and ignores those bits
    logic next_wave;
    always_comb begin
        next_wave = 1'b0;
        if (is_pwm) begin
            next_wave = run & pwm_act;
        end else if (is_pulse) begin
            next_wave = next_run;
        end
    end

    // pin level: forced in pwm 00/01, mapped otherwise; capture keeps low
    wire pin_lvl = (is_pwm && cfg.pinf == stm_pkg::PINF_LOW)  ? 1'b0 :
                   (is_pwm && cfg.pinf == stm_pkg::PINF_HIGH) ? 1'b1 :
                   is_cap ? 1'b0 :
                   ((next_wave ? cfg.ocl : ~cfg.ocl) ^ cfg.pol);

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wave      <= 1'b0;
            timer_out <= 1'b0;
            timer_irq <= 1'b0;
        end else begin
            wave      <= next_wave;
            timer_out <= pin_lvl;
            timer_irq <= irq_a | irq_p;
        end
    end

    // ----------------------------------------------------------------
    // read port
    // ----------------------------------------------------------------
    logic [7:0] rsel;
    always_comb begin
        unique case (addr)
            stm_pkg::ADDR_CTRL0:   rsel = ctrl0;
            stm_pkg::ADDR_CTRL1:   rsel = cfg;
            stm_pkg::ADDR_CNT_LO:  rsel = cnt[7:0];
            stm_pkg::ADDR_CNT_HI:  rsel = cnt[15:8];
            stm_pkg::ADDR_CMPA_LO: rsel = compare_register_a[7:0];
            stm_pkg::ADDR_CMPA_HI: rsel = compare_register_a[15:8];
            stm_pkg::ADDR_CMPP:    rsel = compare_register_p;
            stm_pkg::ADDR_STATUS:  rsel = {5'h00, wave, flags};
            default:               rsel = 8'h00;
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= 8'h00;
        end else begin
            rdata <= rd ? rsel : 8'h00;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    a_run_starts_zero: assert property (@(posedge mclk) disable iff (!rst_n)
        run_rise |=> cnt == '0) else $error("counter not zeroed on run");
    a_pulse_match_stop: assert property (@(posedge mclk) disable iff (!rst_n)
        pulse_end && !wr_ctrl0 |=> !run) else $error("run not cleared on match");
    a_pulse_match_irq: assert property (@(posedge mclk) disable iff (!rst_n)
        pulse_end |=> timer_irq) else $error("no irq on pulse match");
    a_trigger_sets_run: assert property (@(posedge mclk) disable iff (!rst_n)
        trg_evt |=> run) else $error("trigger did not set run");
    a_capture_latch: assert property (@(posedge mclk) disable iff (!rst_n)
        cap_evt |=> compare_register_a == $past(cnt) && timer_irq)
        else $error("capture latch wrong");
    a_cap_p_clear: assert property (@(posedge mclk) disable iff (!rst_n)
        is_cap && run && hit_p && !run_rise |=> cnt == '0) else $error("p clear missed");
    a_cap_disabled: assert property (@(posedge mclk) disable iff (!rst_n)
        is_cap && cfg.pinf == stm_pkg::PINF_ONE |-> !cap_evt)
        else $error("capture while disabled");
    a_pwm_forced_run: assert property (@(posedge mclk) disable iff (!rst_n)
        is_pwm && run && !pwm_clr && !run_rise && !wr_ctrl0 |=> cnt == $past(cnt) + 1'b1)
        else $error("pwm count stalled");
    a_pwm_period_clr: assert property (@(posedge mclk) disable iff (!rst_n)
        is_pwm && run && pwm_clr && !run_rise |=> cnt == '0) else $error("period clear missed");

    // counting, pulse-shape and p-match irq checks
    // pulse start step: run about to rise while in pulse mode
    sequence s_pulse_start;
        is_pulse && !run && next_run;
    endsequence
    a_pulse_lead_edge: assert property (@(posedge mclk) disable iff (!rst_n)
        s_pulse_start |=> timer_out == ($past(cfg.ocl) ^ $past(cfg.pol)))
        else $error("pulse leading edge wrong");
    a_pulse_stays_on: assert property (@(posedge mclk) disable iff (!rst_n)
        is_pulse && run && !hit_a && !wr_ctrl0 |=> run)
        else $error("pulse ended early");
    a_pulse_cnt_hold: assert property (@(posedge mclk) disable iff (!rst_n)
        is_pulse && !run |=> $stable(cnt))
        else $error("stopped pulse counter moved");
    a_cap_free_run: assert property (@(posedge mclk) disable iff (!rst_n)
        is_cap && run && !hit_p && !run_rise |=> cnt == $past(cnt) + 1'b1)
        else $error("capture counter stalled");
    a_cap_p_irq: assert property (@(posedge mclk) disable iff (!rst_n)
        is_cap && run && hit_p |=> timer_irq)
        else $error("no irq on p match");

endmodule

// >>> stm_pkg.sv
// package of constants and carrier types for the standard timer block
package stm_pkg;

    // ----------------------------------------------------------------
    // register map (byte offsets on the plain register port)
    // ----------------------------------------------------------------
    localparam logic [3:0] ADDR_CTRL0    = 4'h0;  // run bit
    localparam logic [3:0] ADDR_CTRL1    = 4'h1;  // mode, pin function, options
    localparam logic [3:0] ADDR_CNT_LO   = 4'h2;  // counter low byte (read only)
    localparam logic [3:0] ADDR_CNT_HI   = 4'h3;  // counter high byte (read only)
    localparam logic [3:0] ADDR_CMPA_LO  = 4'h4;  // compare register a low byte
    localparam logic [3:0] ADDR_CMPA_HI  = 4'h5;  // compare register a high byte
    localparam logic [3:0] ADDR_CMPP     = 4'h6;  // compare register p
    localparam logic [3:0] ADDR_STATUS   = 4'h7;  // sticky match flags, write one to clear

    // ----------------------------------------------------------------
    // field positions in ctrl1 and ctrl0
    // ----------------------------------------------------------------
    localparam int POS_MODE  = 6;  // timer_mode_field [7:6]
    localparam int POS_PINF  = 4;  // pin_function_select [5:4]
    localparam int POS_OCL   = 3;  // output_initial_level
    localparam int POS_POL   = 2;  // output_polarity_invert
    localparam int POS_SWAP  = 1;  // period_duty_swap_select
    localparam int POS_CLRS  = 0;  // counter_clear_source_select
    localparam int POS_SRC   = 7;  // ctrl0 bit 7: capture source (1 = filter)
    localparam int POS_TEDGE = 6;  // ctrl0 bit 6: trigger pin edge (1 = falling)
    localparam int POS_RUN   = 0;  // ctrl0 bit 0: timer_run_bit

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [7:0]  RST_BYTE = 8'h00;
    localparam logic [15:0] RST_WORD = 16'h0000;

    // ----------------------------------------------------------------
    // modes and pin functions
    // ----------------------------------------------------------------
    localparam logic [1:0] MODE_CMP  = 2'h0;  // compare match (not built)
    localparam logic [1:0] MODE_CAP  = 2'h1;  // capture input
    localparam logic [1:0] MODE_PWM  = 2'h2;  // pwm or single pulse
    localparam logic [1:0] MODE_TMR  = 2'h3;  // timer/counter (not built)
    localparam logic [1:0] PINF_LOW  = 2'h0;  // pwm: forced low / cap: rising
    localparam logic [1:0] PINF_HIGH = 2'h1;  // pwm: forced high / cap: falling
    localparam logic [1:0] PINF_PWM  = 2'h2;  // pwm: waveform / cap: both
    localparam logic [1:0] PINF_ONE  = 2'h3;  // single pulse / cap: disabled

    // ----------------------------------------------------------------
    // timing: clock and the 256-clock compare p granule
    // ----------------------------------------------------------------
    localparam int CLK_NS      = 50;   // mclk period in ns
    localparam int P_GRANULE   = 256;  // clocks per compare p step
    localparam int FULL_PERIOD = 65536;

    // ----------------------------------------------------------------
    // carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [1:0] mode;    // timer_mode_field
        logic [1:0] pinf;    // pin_function_select
        logic       ocl;     // output_initial_level
        logic       pol;     // output_polarity_invert
        logic       swap;    // period_duty_swap_select
        logic       clrs;    // counter_clear_source_select
    } stm_cfg_t;

    typedef struct packed {
        logic [3:0] addr;    // register offset
        logic [7:0] wdata;   // write data
        logic       wr;      // write strobe
        logic       rd;      // read strobe
    } stm_bus_t;

endpackage

// >>> stm_edge.sv
// edge detector for a synchronous level: rise and fall
`timescale 1ns/1ns
module stm_edge (
    input  wire logic mclk,   // system clock
    input  wire logic rst_n,  // async reset, active low
    input  wire logic din,    // level to watch
    output logic      rise,   // one-cycle pulse on 0->1
    output logic      fall    // one-cycle pulse on 1->0
);

    logic prev;  // last sample of din

    // ----------------------------------------------------------------
    // sample history
    // ----------------------------------------------------------------
    // remember previous level
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            prev <= 1'b0;
        end else begin
            prev <= din;
        end
    end

    assign rise = din & ~prev;
    assign fall = ~din & prev;

endmodule

// >>> stm_cmp.sv
// comparator pair: compare a on all 16 bits, compare p on the top byte
`timescale 1ns/1ns
module stm_cmp #(
    parameter int W = 16  // counter width
) (
    input  wire logic [W-1:0] cnt,    // counter value
    input  wire logic [W-1:0] cmpa,   // compare register a
    input  wire logic [7:0]   cmpp,   // compare register p
    output logic              hit_a,  // counter equals compare a
    output logic              hit_p   // counter reached the end of a p period
);

    // ----------------------------------------------------------------
    // match decode
    // ----------------------------------------------------------------
    assign hit_a = (cnt == cmpa);
    // p compares the top byte; zero means the full 65536 wrap
    assign hit_p = (cmpp == 8'h00) ? (cnt == {W{1'b1}})
                 : ((cnt[W-1:W-8] == cmpp - 8'h01) && (cnt[W-9:0] == {(W-8){1'b1}}));

endmodule

// >>> stm_far.sv
// far-side model: capture, filter and trigger pin drivers plus output load meter
`timescale 1ns/1ns
module stm_far (
    input  wire logic       mclk,                   // system clock
    input  wire logic       timer_out,              // output pin load
    input  wire logic [2:0] lvl,                    // wanted levels: trigger, filter, capture
    output logic            capture_input_pin,      // capture source pin
    output logic            noise_filter_input_pin, // filtered capture source
    output logic            external_trigger_pin,   // pulse trigger pin
    output int              hi_len,                 // last high time of the output, clocks
    output int              per_len                 // last rise-to-rise time, clocks
);
    int   cnt;     // free cycle count
    int   rise_t;  // cycle of the last output rise
    logic last;    // output level one cycle back

    initial begin
        {capture_input_pin, noise_filter_input_pin, external_trigger_pin, last} = 4'h0;
        {cnt, rise_t, hi_len, per_len} = '0;
    end

    // pins change only just after an edge; output edges are timed in clocks
    always @(posedge mclk) begin
        cnt <= cnt + 1;
        capture_input_pin <= lvl[0];
        noise_filter_input_pin <= lvl[1];
        external_trigger_pin <= lvl[2];
        last <= timer_out;
        if (timer_out && !last) begin
            per_len <= cnt - rise_t;
            rise_t <= cnt;
        end
        if (!timer_out && last) begin
            hi_len <= cnt - rise_t;
        end
    end
endmodule

// >>> stm_timer_tb.sv
// self-checking bench for the standard timer block
`timescale 1ns/1ns
module stm_timer_tb;
    logic       mclk, rst_n, wr, rd, timer_out, timer_irq;
    logic [3:0] addr;
    logic [7:0] wdata, rdata;
    logic [2:0] lvl;
    logic       cap_pin, flt_pin, trg_pin;
    int         hi_len, per_len, cyc, fail_count, num_checks;

    stm_timer i_stm_timer (.mclk(mclk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .external_trigger_pin(trg_pin), .capture_input_pin(cap_pin),
        .noise_filter_input_pin(flt_pin), .timer_out(timer_out), .timer_irq(timer_irq));
    stm_far i_stm_far (.mclk(mclk), .timer_out(timer_out), .lvl(lvl),
        .capture_input_pin(cap_pin), .noise_filter_input_pin(flt_pin),
        .external_trigger_pin(trg_pin), .hi_len(hi_len), .per_len(per_len));

    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    always @(posedge mclk) cyc <= cyc + 1;

    // ------------------------------------------------------------
    // bus, wait and compare helpers
    // ------------------------------------------------------------
    task check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task wreg(input logic [3:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
        @(posedge mclk);
    endtask
    task rreg(input logic [3:0] a, output logic [7:0] d);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1 d = rdata;
        @(posedge mclk);
    endtask
    // wait for the next request pulse, lim edges at most, n edges seen
    task wirq(input int lim, output int n);
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (timer_irq !== 1'b1 && n < lim);
    endtask
    // move one pin, expect a request or not, fetch compare a
    task ev(input int ch, input logic v, input logic ex, output logic [15:0] c, output int t);
        int n;
        t = cyc;
        lvl[ch] <= v;
        wirq(8, n);
        check(timer_irq, {15'h0, ex});
        if (ex) begin
            rreg(stm_pkg::ADDR_CMPA_LO, c[7:0]);
            rreg(stm_pkg::ADDR_CMPA_HI, c[15:8]);
        end
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task t_reset;
        logic [7:0] d;
        wreg(4'hA, 8'hFF);
        for (int i = 0; i < 11; i++) begin
            rreg(i[3:0], d);
            check({8'h00, d}, 16'h0000);
        end
    endtask
    // each edge code; capture spacing must equal pin spacing
    task t_cap;
        logic [15:0] a, b, c;
        int          ta, tb2, tc;
        logic        v, ex;
        for (int e = 0; e < 4; e++) begin
            wreg(stm_pkg::ADDR_CTRL0, 8'h00);
            wreg(stm_pkg::ADDR_CTRL1, {stm_pkg::MODE_CAP, e[1:0], 4'hF});
            wreg(stm_pkg::ADDR_CTRL0, 8'h01);
            for (int i = 0; i < 4; i++) begin
                v = ~i[0];
                ex = (e == 2) || (e == 0 && v) || (e == 1 && !v);
                ev(0, v, ex, c, tc);
                if (ex) begin
                    a = b;
                    ta = tb2;
                    b = c;
                    tb2 = tc;
                end
            end
            if (e < 3) check(b - a, tb2 - ta);
            check(timer_out, 16'h0000);
        end
    endtask
    task t_filt;
        logic [15:0] c;
        int          t;
        wreg(stm_pkg::ADDR_CTRL0, 8'h00);
        wreg(stm_pkg::ADDR_CTRL1, 8'h40);
        wreg(stm_pkg::ADDR_CTRL0, 8'h81);
        ev(0, 1'b1, 1'b0, c, t);
        ev(1, 1'b1, 1'b1, c, t);
        ev(1, 1'b0, 1'b0, c, t);
    endtask
    task t_pmatch;
        int n;
        wreg(stm_pkg::ADDR_CTRL0, 8'h00);
        wreg(stm_pkg::ADDR_CMPP, 8'h01);
        wreg(stm_pkg::ADDR_CTRL1, 8'h70);
        wreg(stm_pkg::ADDR_CTRL0, 8'h01);
        wirq(600, n);
        wirq(600, n);
        check(n, 16'h0100);
    endtask
    // two widths from compare a, then a trigger-pin start
    task t_pulse;
        logic [7:0] d;
        int         n;
        int         w [3];
        wreg(stm_pkg::ADDR_CTRL0, 8'h00);
        wreg(stm_pkg::ADDR_CMPA_HI, 8'h00);
        wreg(stm_pkg::ADDR_CTRL1, 8'hBB);
        for (int k = 0; k < 3; k++) begin
            wreg(stm_pkg::ADDR_CMPA_LO, (k == 1) ? 8'h1E : 8'h14);
            if (k == 2) lvl[2] <= 1'b1;
            else wreg(stm_pkg::ADDR_CTRL0, 8'h01);
            wirq(200, n);
            check(timer_irq, 16'h0001);
            repeat (4) @(posedge mclk);
            lvl[2] <= 1'b0;
            rreg(stm_pkg::ADDR_CTRL0, d);
            check({15'h0, d[0]}, 16'h0000);
            w[k] = hi_len;
        end
        check(w[1] - w[0], 16'h000A);
        check(w[2] - w[0], 16'h0000);
    endtask
    task t_pwm;
        logic [15:0] p0;
        wreg(stm_pkg::ADDR_CTRL0, 8'h00);
        wreg(stm_pkg::ADDR_CMPA_LO, 8'h58);
        wreg(stm_pkg::ADDR_CMPA_HI, 8'h02);
        wreg(stm_pkg::ADDR_CMPP, 8'h01);
        wreg(stm_pkg::ADDR_CTRL1, 8'hAA);
        wreg(stm_pkg::ADDR_CTRL0, 8'h01);
        repeat (1400) @(posedge mclk);
        check(hi_len, 16'h0100);
        p0 = per_len;
        wreg(stm_pkg::ADDR_CTRL1, 8'hAB);
        wreg(stm_pkg::ADDR_CMPA_LO, 8'hBC);
        repeat (1600) @(posedge mclk);
        check(per_len - p0, 16'h0064);
        wreg(stm_pkg::ADDR_CTRL1, 8'h9B);
        @(posedge mclk);
        check(timer_out, 16'h0001);
        wreg(stm_pkg::ADDR_CTRL1, 8'h8B);
        @(posedge mclk);
        check(timer_out, 16'h0000);
        wreg(stm_pkg::ADDR_CTRL1, 8'hAB);
        repeat (1600) @(posedge mclk);
        check(per_len - p0, 16'h0064);
    endtask

    task finish_test;
        $display("checks %0d, mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    initial begin
        {rst_n, wr, rd, addr, wdata, lvl} = '0;
        {cyc, fail_count, num_checks} = '0;
        repeat (5) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        t_reset();
        t_cap();
        t_filt();
        t_pmatch();
        t_pulse();
        t_pwm();
        finish_test();
    end
    // watchdog against a hung wait
    initial begin
        repeat (40000) @(posedge mclk);
        fail_count++;
        finish_test();
    end
endmodule
